// File: design/csf_pkg.sv
package csf_pkg;
   // apb register map (byte addresses)
   localparam logic [7:0] CSF_ADDR_STATUS  = 8'h00;
   localparam logic [7:0] CSF_ADDR_PCL     = 8'h04;
   localparam logic [7:0] CSF_ADDR_LOOKUP_POINTER    = 8'h08;
   localparam logic [7:0] CSF_ADDR_PCH     = 8'h0C;
   localparam logic [7:0] CSF_ADDR_TBDATA  = 8'h10;
   localparam logic [7:0] CSF_ADDR_IRQ_ST  = 8'h14;
   localparam logic [7:0] CSF_ADDR_IRQ_MSK = 8'h18;
   localparam logic [7:0] CSF_ADDR_CMD     = 8'h1C;
   localparam logic [7:0] CSF_ADDR_ALU     = 8'h20;
   // status bit positions
   localparam int CSF_BIT_C   = 0;
   localparam int CSF_BIT_AC  = 1;
   localparam int CSF_BIT_Z   = 2;
   localparam int CSF_BIT_OV  = 3;
   localparam int CSF_BIT_PDF = 4;
   localparam int CSF_BIT_TO  = 5;
   // command register bits (write-one pulses)
   localparam int CSF_CMD_KICK = 0;
   localparam int CSF_CMD_STOP = 1;
   localparam int CSF_CMD_TMO  = 2;
   // interrupt status bits
   localparam int CSF_IRQ_TMO  = 0;
   localparam int CSF_IRQ_STOP = 1;
   localparam int CSF_IRQ_JUMP = 2;
   // reset values
   localparam logic [7:0]  CSF_RST_STATUS = 8'h00;
   localparam logic [7:0]  CSF_RST_BYTE   = 8'h00;
   localparam logic [2:0]  CSF_RST_IRQ    = 3'h0;
   localparam logic [31:0] CSF_RST_WORD   = 32'h0000_0000;
   // idle cycles after a jump
   localparam int CSF_JUMP_IDLE = 1;
   // alu operations
   typedef enum logic [2:0] {
      CSF_OP_ADD = 3'b000,
      CSF_OP_SUB = 3'b001,
      CSF_OP_AND = 3'b010,
      CSF_OP_OR  = 3'b011,
      CSF_OP_XOR = 3'b100,
      CSF_OP_RLC = 3'b101,
      CSF_OP_RRC = 3'b110
   } csf_op_t;
   typedef enum logic [1:0] {
      CSF_ST_RUN  = 2'b00,
      CSF_ST_IDLE = 2'b01,
      CSF_ST_TBL  = 2'b10
   } csf_state_t;
endpackage : csf_pkg

// File: design/csf_alu_if.sv
interface csf_alu_if;
   import csf_pkg::*;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   csf_op_t    op;
   logic [7:0] res;
   logic       c;
   logic       ac;
   logic       z;
   logic       ov;
   modport core (output a, b, cin, op, input res, c, ac, z, ov);
   modport alu  (input a, b, cin, op, output res, c, ac, z, ov);
endinterface : csf_alu_if

// File: design/csf_alu.sv
module csf_alu (
   csf_alu_if.alu bus
);
   import csf_pkg::*;
   logic [4:0] lo;
   logic [7:0] sum7;
   logic [8:0] full;
   logic [7:0] bb;
   logic       isub;
   logic [7:0] res_w;
   logic       c_w;
   assign isub = (bus.op == CSF_OP_SUB);
   // subtraction as a + ~b + 1: carry out means no borrow
   assign bb   = isub ? ~bus.b : bus.b;
   assign lo   = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, isub};
   assign sum7 = {1'b0, bus.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, isub};
   assign full = {1'b0, bus.a} + {1'b0, bb} + {8'h00, isub};
   always_comb begin
      res_w = full[7:0];
      c_w   = full[8];
      case (bus.op)
         CSF_OP_ADD, CSF_OP_SUB: begin
            res_w = full[7:0];
            c_w   = full[8];
         end
         CSF_OP_AND: res_w = bus.a & bus.b;
         CSF_OP_OR:  res_w = bus.a | bus.b;
         CSF_OP_XOR: res_w = bus.a ^ bus.b;
         CSF_OP_RLC: begin
            res_w = {bus.a[6:0], bus.cin};
            c_w   = bus.a[7];
         end
         CSF_OP_RRC: begin
            res_w = {bus.cin, bus.a[7:1]};
            c_w   = bus.a[0];
         end
         default: res_w = full[7:0];
      endcase
   end
   assign bus.res = res_w;
   assign bus.c   = c_w;
   assign bus.ac  = lo[4];
   assign bus.z   = (res_w == 8'h00);
   // carry into bit 7 differs from carry out
   assign bus.ov  = sum7[7] ^ full[8];
endmodule : csf_alu

// File: design/csf_core.sv
// Functional notes
// - writing the low pc byte jumps within the current page only
// - a low pc write inserts one idle cycle before continuing
// - lookup pointer addresses table reads; low byte goes to the table data register
// - software writes to status never change the expiry and sleep flags
// - expiry flag set by time-out, cleared by reset, kick or stop
// - sleep flag set by stop, cleared by reset or kick only
// - carry bit from add carry or subtract no-borrow, and rotates
// - half carry from low nibble carry or no nibble borrow
// - zero flag set when result is zero, cleared otherwise
// - overflow when carry into msb differs from carry out
// - arithmetic flags readable and writable by software
// - status bits 7 and 6 read as zero
// - status is never pushed on calls or interrupts
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module csf_core (
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output      logic [31:0] o_prdata,
   output      logic        o_pready,
   output      logic        o_pslverr,
   // program memory table port
   output      logic [9:0]  o_tbl_addr,
   input  wire logic [11:0] i_tbl_data,
   // watchdog time-out event
   input  wire logic        i_wdt_timeout,
   // program counter and interrupt
   output      logic [9:0]  o_pc,
   output      logic        o_cpu_stall,
   output      logic        o_irq
);
   import csf_pkg::*;

   csf_alu_if alu_bus ();
   csf_alu u_alu (
      .bus (alu_bus)
   );

   logic [7:0]  status_r;
   logic [7:0]  pcl_r;
   logic [1:0]  pch_r;
   logic [7:0]  lookup_pointer_r;
   logic [7:0]  tbdata_r;
   logic [7:0]  alu_res_r;
   logic [2:0]  irq_st_r;
   logic [2:0]  irq_msk_r;
   logic [31:0] prdata_r;
   logic        ready_r;
   logic        slverr_r;
   logic        irq_r;
   csf_state_t  state_r;
   csf_state_t  state_nxt;

   // apb decode
   wire acc_w     = i_psel && i_penable && !ready_r;
   wire wr_w      = acc_w && i_pwrite;
   wire rd_w      = acc_w && !i_pwrite;
   wire sel_st    = (i_paddr == CSF_ADDR_STATUS);
   wire sel_pcl   = (i_paddr == CSF_ADDR_PCL);
   wire sel_lookup_pointer  = (i_paddr == CSF_ADDR_LOOKUP_POINTER);
   wire sel_pch   = (i_paddr == CSF_ADDR_PCH);
   wire sel_tbd   = (i_paddr == CSF_ADDR_TBDATA);
   wire sel_ist   = (i_paddr == CSF_ADDR_IRQ_ST);
   wire sel_imsk  = (i_paddr == CSF_ADDR_IRQ_MSK);
   wire sel_cmd   = (i_paddr == CSF_ADDR_CMD);
   wire sel_alu   = (i_paddr == CSF_ADDR_ALU);
   wire mapped_w  = sel_st | sel_pcl | sel_lookup_pointer | sel_pch | sel_tbd | sel_ist
                  | sel_imsk | sel_cmd | sel_alu;

   // command pulses
   wire kick_w    = wr_w && sel_cmd && i_pwdata[CSF_CMD_KICK];
   wire stop_w    = wr_w && sel_cmd && i_pwdata[CSF_CMD_STOP];
   wire tbl_go_w  = wr_w && sel_cmd && i_pwdata[CSF_CMD_TMO];
   wire jump_w    = wr_w && sel_pcl;
   wire alu_go_w  = wr_w && sel_alu;
   wire st_wr_w   = wr_w && sel_st;

   // alu operands: a=[7:0], b=[15:8], op=[18:16]
   assign alu_bus.a   = i_pwdata[7:0];
   assign alu_bus.b   = i_pwdata[15:8];
   assign alu_bus.op  = csf_op_t'(i_pwdata[18:16]);
   assign alu_bus.cin = status_r[CSF_BIT_C];
   wire arith_w   = (alu_bus.op == CSF_OP_ADD) || (alu_bus.op == CSF_OP_SUB);
   wire rot_w     = (alu_bus.op == CSF_OP_RLC) || (alu_bus.op == CSF_OP_RRC);

   // status next value
   logic [7:0] status_nxt;
   always_comb begin
      status_nxt = status_r;
      if (st_wr_w) begin
         status_nxt[3:0] = i_pwdata[3:0];
      end
      if (alu_go_w) begin
         status_nxt[CSF_BIT_Z] = alu_bus.z;
         if (arith_w || rot_w) begin
            status_nxt[CSF_BIT_C] = alu_bus.c;
         end
         if (arith_w) begin
            status_nxt[CSF_BIT_AC] = alu_bus.ac;
            status_nxt[CSF_BIT_OV] = alu_bus.ov;
         end
      end
      if (kick_w) begin
         status_nxt[CSF_BIT_PDF] = 1'b0;
      end else if (stop_w) begin
         status_nxt[CSF_BIT_PDF] = 1'b1;
      end
      if (i_wdt_timeout) begin
         status_nxt[CSF_BIT_TO] = 1'b1;
      end else if (kick_w || stop_w) begin
         status_nxt[CSF_BIT_TO] = 1'b0;
      end
      status_nxt[7:6] = 2'b00;
   end

   // status has no stack copy; software saves it
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         status_r <= CSF_RST_STATUS;
      end else begin
         status_r <= status_nxt;
      end
   end

   // sequencer: idle cycle after jump, table fetch cycle
   always_comb begin
      state_nxt = CSF_ST_RUN;
      case (state_r)
         CSF_ST_RUN: begin
            if (jump_w) begin
               state_nxt = CSF_ST_IDLE;
            end else if (tbl_go_w) begin
               state_nxt = CSF_ST_TBL;
            end
         end
         CSF_ST_IDLE: state_nxt = CSF_ST_RUN;
         CSF_ST_TBL:  state_nxt = CSF_ST_RUN;
         default:     state_nxt = CSF_ST_RUN;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_r <= CSF_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         pcl_r <= CSF_RST_BYTE;
         pch_r <= 2'b00;
      end else if (jump_w) begin
         pcl_r <= i_pwdata[7:0];
      end else if (wr_w && sel_pch) begin
         pch_r <= i_pwdata[1:0];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         lookup_pointer_r   <= CSF_RST_BYTE;
         tbdata_r <= CSF_RST_BYTE;
      end else begin
         if (wr_w && sel_lookup_pointer) begin
            lookup_pointer_r <= i_pwdata[7:0];
         end
         if (state_r == CSF_ST_TBL) begin
            tbdata_r <= i_tbl_data[7:0];
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         alu_res_r <= CSF_RST_BYTE;
      end else if (alu_go_w) begin
         alu_res_r <= alu_bus.res;
      end
   end

   // interrupt status: set wins over write-one clear
   wire [2:0] irq_ev_w  = {jump_w, stop_w, i_wdt_timeout};
   wire [2:0] irq_clr_w = (wr_w && sel_ist) ? i_pwdata[2:0] : 3'h0;
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         irq_st_r  <= CSF_RST_IRQ;
         irq_msk_r <= CSF_RST_IRQ;
         irq_r     <= 1'b0;
      end else begin
         irq_st_r <= (irq_st_r & ~irq_clr_w) | irq_ev_w;
         if (wr_w && sel_imsk) begin
            irq_msk_r <= i_pwdata[2:0];
         end
         irq_r <= |(((irq_st_r & ~irq_clr_w) | irq_ev_w) & irq_msk_r);
      end
   end

   // read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = CSF_RST_WORD;
      case (1'b1)
         sel_st:   rd_mux = {24'h00_0000, status_r};
         sel_pcl:  rd_mux = {24'h00_0000, pcl_r};
         sel_lookup_pointer: rd_mux = {24'h00_0000, lookup_pointer_r};
         sel_pch:  rd_mux = {30'h0000_0000, pch_r};
         sel_tbd:  rd_mux = {24'h00_0000, tbdata_r};
         sel_ist:  rd_mux = {29'h0000_0000, irq_st_r};
         sel_imsk: rd_mux = {29'h0000_0000, irq_msk_r};
         sel_alu:  rd_mux = {24'h00_0000, alu_res_r};
         default:  rd_mux = CSF_RST_WORD;
      endcase
   end

   // one-cycle-late answer
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         ready_r  <= 1'b0;
         slverr_r <= 1'b0;
         prdata_r <= CSF_RST_WORD;
      end else begin
         ready_r  <= acc_w;
         slverr_r <= acc_w && !mapped_w;
         if (rd_w) begin
            prdata_r <= rd_mux;
         end
      end
   end

   assign o_prdata    = prdata_r;
   assign o_pready    = ready_r;
   assign o_pslverr   = slverr_r;
   assign o_pc        = {pch_r, pcl_r};
   assign o_tbl_addr  = {pch_r, lookup_pointer_r};
   assign o_cpu_stall = (state_r != CSF_ST_RUN);
   assign o_irq       = irq_r;

   // assertions
   AST_JUMP_PAGE: assert property (@(posedge i_core_clk) disable iff (i_reset)
      jump_w |=> (o_pc[9:8] == $past(pch_r)) && (o_pc[7:0] == $past(i_pwdata[7:0])))
      else $error("jump left the page");
   AST_JUMP_IDLE: assert property (@(posedge i_core_clk) disable iff (i_reset)
      jump_w |=> o_cpu_stall ##1 !o_cpu_stall)
      else $error("jump idle cycle wrong");
   AST_TBL_FETCH: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (state_r == CSF_ST_TBL) |=> tbdata_r == $past(i_tbl_data[7:0]))
      else $error("table byte not captured");
   AST_SYS_KEEP: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (st_wr_w && !kick_w && !stop_w && !i_wdt_timeout) |=> status_r[5:4] == $past(status_r[5:4]))
      else $error("status write changed system flags");
   AST_TO_SET: assert property (@(posedge i_core_clk) disable iff (i_reset)
      i_wdt_timeout |=> status_r[CSF_BIT_TO])
      else $error("time-out flag not set");
   AST_PDF_SET: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (stop_w && !kick_w) |=> status_r[CSF_BIT_PDF] && (status_r[CSF_BIT_TO] == $past(i_wdt_timeout)))
      else $error("stop flags wrong");
   AST_CARRY: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (alu_go_w && (alu_bus.op == CSF_OP_ADD)) |=>
         status_r[CSF_BIT_C] == ($past({1'b0, i_pwdata[7:0]}) + $past({1'b0, i_pwdata[15:8]})) >> 8)
      else $error("carry wrong");
   AST_ZERO: assert property (@(posedge i_core_clk) disable iff (i_reset)
      alu_go_w |=> status_r[CSF_BIT_Z] == (alu_res_r == 8'h00))
      else $error("zero flag wrong");
   AST_TOP_ZERO: assert property (@(posedge i_core_clk) disable iff (i_reset)
      status_r[7:6] == 2'b00)
      else $error("unimplemented bits set");
   AST_IRQ: assert property (@(posedge i_core_clk) disable iff (i_reset)
      $rose(i_wdt_timeout) && irq_msk_r[CSF_IRQ_TMO] |=> ##1 o_irq)
      else $error("interrupt missing");

   // subtract carry is the no-borrow condition
   AST_SUB_CARRY: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (alu_go_w && (alu_bus.op == CSF_OP_SUB)) |=>
         status_r[CSF_BIT_C] == $past(i_pwdata[7:0] >= i_pwdata[15:8]))
      else $error("subtract carry wrong");

   // rotate left shifts the old top bit into carry
   AST_ROT_CARRY: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (alu_go_w && (alu_bus.op == CSF_OP_RLC)) |=>
         status_r[CSF_BIT_C] == $past(i_pwdata[7]))
      else $error("rotate carry wrong");

   // nibble carry on addition
   AST_HALF_CARRY: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (alu_go_w && (alu_bus.op == CSF_OP_ADD)) |=>
         status_r[CSF_BIT_AC] == $past(({1'b0, i_pwdata[3:0]} + {1'b0, i_pwdata[11:8]}) >> 4))
      else $error("half carry wrong");

   // signed overflow: like-signed operands give a result of the other sign
   AST_OVF: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (alu_go_w && (alu_bus.op == CSF_OP_ADD)) |=>
         status_r[CSF_BIT_OV] == ($past(i_pwdata[7] == i_pwdata[15])
                                  && ($past(i_pwdata[7]) != alu_res_r[7])))
      else $error("overflow flag wrong");

   // software write lands in the arithmetic flags
   AST_FLAG_WR: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (st_wr_w && !alu_go_w) |=> status_r[3:0] == $past(i_pwdata[3:0]))
      else $error("flag write lost");

   // kick or stop clears expiry unless a time-out arrives
   AST_TO_CLR: assert property (@(posedge i_core_clk) disable iff (i_reset)
      ((kick_w || stop_w) && !i_wdt_timeout) |=> !status_r[CSF_BIT_TO])
      else $error("expiry flag not cleared");

   // kick clears the sleep flag
   AST_PDF_CLR: assert property (@(posedge i_core_clk) disable iff (i_reset)
      kick_w |=> !status_r[CSF_BIT_PDF])
      else $error("sleep flag not cleared");

   // system flags hold when no system event occurs
   AST_SYS_HOLD: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (!kick_w && !stop_w && !i_wdt_timeout) |=> status_r[5:4] == $past(status_r[5:4]))
      else $error("system flags moved");

   // each access phase gets a one-cycle ready pulse
   AST_READY: assert property (@(posedge i_core_clk) disable iff (i_reset)
      acc_w |=> o_pready ##1 !o_pready)
      else $error("ready pulse wrong");

   COV_TBL:  cover property (@(posedge i_core_clk) state_r == CSF_ST_TBL);

   COV_JUMP: cover property (@(posedge i_core_clk) jump_w);
   COV_STOP: cover property (@(posedge i_core_clk) stop_w);
   COV_TMO:  cover property (@(posedge i_core_clk) i_wdt_timeout ##1 kick_w);
   COV_SUB:  cover property (@(posedge i_core_clk) alu_go_w && alu_bus.op == CSF_OP_SUB);
endmodule : csf_core

// File: verif/test_cpu_status_flags_and_pc_low.sv
module test_cpu_status_flags_and_pc_low;
   timeunit 1ns;
   timeprecision 1ps;
   import csf_pkg::*;

   logic        i_core_clk;
   logic        i_reset;
   logic        i_psel;
   logic        i_penable;
   logic        i_pwrite;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata;
   logic [31:0] o_prdata;
   logic        o_pready;
   logic        o_pslverr;
   logic [9:0]  o_tbl_addr;
   logic [11:0] i_tbl_data;
   logic        i_wdt_timeout;
   logic [9:0]  o_pc;
   logic        o_cpu_stall;
   logic        o_irq;
   int          n_fail;
   int          comparisons;
   int          stall_cnt;
   logic [31:0] rdat;
   logic        rerr;
   // {op, b, a} per alu step and the expected {result, status}
   logic [18:0] alu_in [13] = '{19'h0_010f, 19'h0_8080, 19'h0_017f, 19'h1_0305, 19'h1_0503,
      19'h1_0180, 19'h2_0ff0, 19'h3_0001, 19'h4_5555, 19'h5_0080, 19'h6_0001, 19'h6_0000,
      19'h5_0000};
   logic [15:0] alu_exp [13] = '{16'h1002, 16'h000d, 16'h800a, 16'h0203, 16'hfe00, 16'h7f09,
      16'h000d, 16'h0109, 16'h000d, 16'h0109, 16'h8009, 16'h8008, 16'h000c};

   csf_core i_dut (
      .i_core_clk    (i_core_clk),
      .i_reset       (i_reset),
      .i_psel        (i_psel),
      .i_penable     (i_penable),
      .i_pwrite      (i_pwrite),
      .i_paddr       (i_paddr),
      .i_pwdata      (i_pwdata),
      .o_prdata      (o_prdata),
      .o_pready      (o_pready),
      .o_pslverr     (o_pslverr),
      .o_tbl_addr    (o_tbl_addr),
      .i_tbl_data    (i_tbl_data),
      .i_wdt_timeout (i_wdt_timeout),
      .o_pc          (o_pc),
      .o_cpu_stall   (o_cpu_stall),
      .o_irq         (o_irq)
   );

   always #5 i_core_clk = ~i_core_clk;

   // program memory answers with a word derived from the fetch address
   always @(posedge i_core_clk) i_tbl_data <= {2'b11, o_tbl_addr ^ 10'h0a5};

   always @(negedge i_core_clk) if (o_cpu_stall === 1'b1) stall_cnt++;

   task wrap_up;
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int n;
      @(posedge i_core_clk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= wr;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      n = 0;
      // read before the edge's updates land: the values sampled at this edge
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         $display("[ERR] %0t no pready", $time);
      end
      rd  = o_prdata;
      err = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        e;
      apb(1'b1, a, d, x, e);
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, x, e);
      chk(x, exp);
   endtask : rd_chk

   task pulse_tmo;
      @(posedge i_core_clk);
      i_wdt_timeout <= 1'b1;
      @(posedge i_core_clk);
      i_wdt_timeout <= 1'b0;
   endtask : pulse_tmo

   task chk_irq(input logic exp);
      @(negedge i_core_clk);
      chk({31'h0, o_irq}, {31'h0, exp});
   endtask : chk_irq

   initial begin
      repeat (5000) @(posedge i_core_clk);
      n_fail++;
      wrap_up;
   end

   initial begin
      i_core_clk = 1'b0; i_reset = 1'b1; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
      i_paddr = 8'h00; i_pwdata = 32'h0000_0000; i_tbl_data = 12'h000; i_wdt_timeout = 1'b0;
      n_fail = 0; comparisons = 0; stall_cnt = 0;
      repeat (4) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0000);
      wr(CSF_ADDR_STATUS, 32'h0000_00ff);
      rd_chk(CSF_ADDR_STATUS, 32'h0000_000f);
      wr(CSF_ADDR_STATUS, 32'h0000_0005);
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0005);
      wr(CSF_ADDR_CMD, 32'h0000_0002);
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0015);
      pulse_tmo();
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0035);
      wr(CSF_ADDR_STATUS, 32'h0000_0000);
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0030);
      wr(CSF_ADDR_CMD, 32'h0000_0001);
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0000);
      pulse_tmo();
      wr(CSF_ADDR_CMD, 32'h0000_0002);
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0010);
      wr(CSF_ADDR_CMD, 32'h0000_0001);
      for (int i = 0; i < 13; i++) begin
         wr(CSF_ADDR_ALU, {13'h0, alu_in[i]});
         rd_chk(CSF_ADDR_STATUS, {24'h0, alu_exp[i][7:0]});
         rd_chk(CSF_ADDR_ALU, {24'h0, alu_exp[i][15:8]});
      end
      wr(CSF_ADDR_PCH, 32'h0000_0001);
      stall_cnt = 0;
      wr(CSF_ADDR_PCL, 32'h0000_005a);
      repeat (3) @(negedge i_core_clk);
      chk({22'h0, o_pc}, 32'h0000_015a);
      chk(32'(stall_cnt), 32'(CSF_JUMP_IDLE));
      wr(CSF_ADDR_PCL, 32'h0000_00ff);
      @(negedge i_core_clk);
      chk({22'h0, o_pc}, 32'h0000_01ff);
      wr(CSF_ADDR_LOOKUP_POINTER, 32'h0000_0034);
      chk({22'h0, o_tbl_addr}, 32'h0000_0134);
      wr(CSF_ADDR_CMD, 32'h0000_0004);
      rd_chk(CSF_ADDR_TBDATA, 32'h0000_0091);
      wr(CSF_ADDR_LOOKUP_POINTER, 32'h0000_0035);
      wr(CSF_ADDR_CMD, 32'h0000_0004);
      rd_chk(CSF_ADDR_TBDATA, 32'h0000_0090);
      rd_chk(CSF_ADDR_IRQ_ST, 32'h0000_0007);
      chk_irq(1'b0);
      wr(CSF_ADDR_IRQ_MSK, 32'h0000_0004);
      chk_irq(1'b1);
      wr(CSF_ADDR_IRQ_ST, 32'h0000_0004);
      chk_irq(1'b0);
      rd_chk(CSF_ADDR_IRQ_ST, 32'h0000_0003);
      wr(CSF_ADDR_IRQ_MSK, 32'h0000_0003);
      chk_irq(1'b1);
      wr(CSF_ADDR_IRQ_ST, 32'h0000_0003);
      chk_irq(1'b0);
      rd_chk(CSF_ADDR_IRQ_ST, 32'h0000_0000);
      apb(1'b1, 8'h24, 32'hffff_ffff, rdat, rerr);
      chk({31'h0, rerr}, 32'h0000_0001);
      apb(1'b0, 8'h24, 32'h0000_0000, rdat, rerr);
      chk({rdat[30:0], rerr}, 32'h0000_0001);
      wr(CSF_ADDR_CMD, 32'h0000_0002);
      @(posedge i_core_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rd_chk(CSF_ADDR_STATUS, 32'h0000_0000);
      wrap_up;
   end
endmodule : test_cpu_status_flags_and_pc_low
